// file: bench/ads_ram_model.sv
// Data RAM write-stage model that stores each accepted word.
`timescale 1ns/1ps
`default_nettype none
module ads_ram_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Write stage
  input  wire logic        ramWrValid,
  input  wire logic [16:0] ramWrData,
  output logic             ramWrReady,
  // Behaviour
  input  wire logic        slow
);
  logic [16:0] words[$];
  logic        phase;
  // A slow RAM refuses every other cycle, so held words must stand.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ramWrReady <= 1'h0;
      phase      <= 1'h0;
    end
    else
    begin
      if (ramWrValid && ramWrReady)
      begin
        words.push_back(ramWrData);
      end
      phase      <= ~phase;
      ramWrReady <= slow ? phase : 1'h1;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the converter DMA status block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    checksDone++; \
    if ((got) !== (exp)) \
    begin \
      nErrors++; \
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp); \
    end \
  end
module tb_top;
  logic        clk_sys = 1'h0;
  logic        arst_n = 1'h0;
  logic [7:0]  sfrAddr = 8'h00;
  logic [7:0]  sfrWrData = 8'h00;
  logic        sfrWrEn = 1'h0;
  logic        sfrRdEn = 1'h0;
  logic [7:0]  sfrRdData;
  logic        c0V = 1'h0;
  logic        c1V = 1'h0;
  logic [15:0] c0D = 16'h0000;
  logic [15:0] c1D = 16'h0000;
  logic [15:0] repCnt = 16'h0000;
  logic [15:0] repLim = 16'h0005;
  logic        ramWrValid;
  logic [16:0] ramWrData;
  logic        ramWrReady;
  logic        dmaIrq;
  logic        dmaEnable;
  logic        dmaMode;
  logic        eop = 1'h0;
  logic        opsDone = 1'h0;
  logic        slow = 1'h0;
  int          nErrors = 0;
  int          checksDone = 0;

  ads_dma_status dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .conv0Valid(c0V),
    .conv0Data(c0D), .conv1Valid(c1V), .conv1Data(c1D),
    .repeatCount(repCnt), .repeatLimit(repLim), .eopReached(eop),
    .opsComplete(opsDone), .ramWrValid(ramWrValid), .ramWrData(ramWrData),
    .ramWrReady(ramWrReady), .dmaEnable(dmaEnable), .dmaMode(dmaMode),
    .dmaIrq(dmaIrq));
  ads_ram_model ram (.clk_sys(clk_sys), .arst_n(arst_n),
    .ramWrValid(ramWrValid), .ramWrData(ramWrData),
    .ramWrReady(ramWrReady), .slow(slow));

  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfrAddr   = a;
    sfrWrData = d;
    sfrWrEn   = 1'h1;
    @(negedge clk_sys);
    sfrWrEn = 1'h0;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic rdReg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrRdEn = 1'h1;
    @(negedge clk_sys);
    sfrRdEn = 1'h0;
    @(negedge clk_sys);
    `CHK(sfrRdData, e, "register read")
  endtask

  // Spacing lets each result settle before the next one arrives.
  task automatic conv(input bit ch, input logic [15:0] d);
    @(negedge clk_sys);
    if (ch)
    begin
      c1D = d;
      c1V = 1'h1;
    end
    else
    begin
      c0D = d;
      c0V = 1'h1;
    end
    @(negedge clk_sys);
    c0V = 1'h0;
    c1V = 1'h0;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic testOverflow();
    bit seen;
    seen = 1'b0;
    wrReg(8'hD9, 8'h80);
    wrReg(8'hD8, 8'h80);
    `CHK(dmaEnable, 1'h1, "enable pin")
    for (int i = 0; i < 12; i++)
    begin
      conv(1'b0, 16'hA00 + i[15:0]);
      seen |= (ramWrValid !== 1'h0);
    end
    conv(1'b1, 16'hB00);
    conv(1'b1, 16'hB01);
    `CHK(seen, 1'b0, "write while halted")
    rdReg(8'hD8, 8'h8B);
    rdReg(8'hD8, 8'h8B);
    `CHK(dmaIrq, 1'h1, "error irq")
    rdReg(8'hD9, 8'hC0);
    $display("overflow test done");
  endtask

  task automatic testDrain();
    int k;
    int n;
    slow = 1'h1;
    wrReg(8'hD9, 8'h00);
    for (n = 0; n < 300 && ram.words.size() < 13; n++)
      @(negedge clk_sys);
    if (n == 300)
    begin
      nErrors++;
      end_of_test();
    end
    k = 0;
    foreach (ram.words[j])
    begin
      if (ram.words[j][16] == 1'b0)
      begin
        `CHK(ram.words[j][15:0], 16'hA00 + (k < 10 ? k : 11), "word")
        k++;
      end
    end
    `CHK(k, 11, "conv0 word count")
    `CHK(ram.words.size(), 13, "word count")
    rdReg(8'hD9, 8'h00);
    $display("drain test done");
  endtask

  task automatic testIrq();
    wrReg(8'hD8, 8'h80);
    rdReg(8'hD8, 8'h80);
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk_sys);
      repCnt = i[15:0];
    end
    rdReg(8'hD9, 8'h04);
    `CHK(dmaIrq, 1'h0, "masked repeat irq")
    wrReg(8'hD9, 8'h0C);
    `CHK(dmaIrq, 1'h1, "repeat irq")
    rdReg(8'hD9, 8'h0C);
    wrReg(8'hD9, 8'h00);
    rdReg(8'hD9, 8'h00);
    wrReg(8'hD8, 8'h83);
    `CHK(dmaIrq, 1'h0, "masked warn irq")
    wrReg(8'hD8, 8'h87);
    `CHK(dmaIrq, 1'h1, "warn irq")
    wrReg(8'hD8, 8'h80);
    `CHK(dmaIrq, 1'h0, "irq cleared")
    @(negedge clk_sys);
    eop = 1'h1;
    @(negedge clk_sys);
    eop = 1'h0;
    rdReg(8'hD9, 8'h01);
    `CHK(dmaIrq, 1'h0, "masked end irq")
    wrReg(8'hD9, 8'h00);
    @(negedge clk_sys);
    opsDone = 1'h1;
    @(negedge clk_sys);
    opsDone = 1'h0;
    rdReg(8'hD8, 8'hC0);
    `CHK(dmaIrq, 1'h1, "done irq")
    $display("irq test done");
  endtask

  initial
  begin
    repeat (8) @(negedge clk_sys);
    arst_n = 1'h1;
    rdReg(8'hD8, 8'h00);
    rdReg(8'hD9, 8'h00);
    rdReg(8'hD7, 8'h00);
    wrReg(8'hD9, 8'hFF);
    rdReg(8'hD9, 8'h8F);
    wrReg(8'hD9, 8'h00);
    wrReg(8'hD8, 8'h20);
    `CHK(dmaMode, 1'h1, "mode pin")
    `CHK(dmaEnable, 1'h0, "enable pin")
    wrReg(8'hD8, 8'h00);
    $display("register test done");
    testOverflow();
    testDrain();
    testIrq();
    end_of_test();
  end
endmodule
`default_nettype wire

// file: verilog/ads_dma_status.sv
// Status, enable and halt logic of the converter-to-RAM DMA engine.
// Function
// - Converter-0 lost result sets sticky error flag.
// - Converter-1 buffer full sets sticky warning flag.
// - Repeat-overflow interrupt enable at configuration bit 3.
// - Repeat-overflow flag at configuration bit 2.
// - Second result while buffer waits flags warning; a third flags error.
// - One warning enable gates both warning interrupts.
// - Repeat overflow when counter reaches its limit.
`timescale 1ns/1ps
`default_nettype none
module ads_dma_status #(
  parameter int DW = ads_pkg::DATA_W,
  parameter int CW = ads_pkg::COUNT_W,
  parameter int FD = ads_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  // Special function register port
  input  wire logic [7:0]    sfrAddr,
  input  wire logic [7:0]    sfrWrData,
  input  wire logic          sfrWrEn,
  input  wire logic          sfrRdEn,
  output logic [7:0]         sfrRdData,
  // Converter results
  input  wire logic          conv0Valid,
  input  wire logic [DW-1:0] conv0Data,
  input  wire logic          conv1Valid,
  input  wire logic [DW-1:0] conv1Data,
  // Sequencer events
  input  wire logic [CW-1:0] repeatCount,
  input  wire logic [CW-1:0] repeatLimit,
  input  wire logic          eopReached,
  input  wire logic          opsComplete,
  // Data RAM write stage
  output logic               ramWrValid,
  output logic [DW:0]        ramWrData,
  input  wire logic          ramWrReady,
  // Status
  output logic               dmaEnable,
  output logic               dmaMode,
  output logic               dmaIrq
);
  typedef struct packed {
    logic [7:0]         ctrl;
    logic [7:0]         cfg;
    logic [1:0]         bufFull;
    logic [1:0]         pendFull;
    logic [1:0][DW-1:0] bufData;
    logic [1:0][DW-1:0] pendData;
    logic               slotFull;
    logic               wrValid;
    logic [DW:0]        wrData;
    logic [7:0]         rdData;
    logic               irq;
    logic               rptHit;
  } ads_top_st_t;

  ads_top_st_t        st;
  ads_top_st_t        nxt_st;
  logic               ctrlWr;
  logic               cfgWr;
  logic               rptNow;
  logic [1:0]         freed;
  logic [1:0]         convIn;
  logic [1:0][DW-1:0] convData;

  ads_fifo_if #(.W(DW+1)) fif ();

  ads_fifo #(
    .W     (DW+1),
    .DEPTH (FD)
  ) u_fifo (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .fif     (fif.store)
  );

  function automatic logic addrHit(input logic [7:0] a,
                                   input logic [7:0] target);
    addrHit = (a == target);
  endfunction

  function automatic logic irqOf(input logic [7:0] c, input logic [7:0] f);
    irqOf = c[ads_pkg::CTL_DONE] | c[ads_pkg::CTL_DE1]
          | c[ads_pkg::CTL_DE0]
          | (c[ads_pkg::CTL_DOE]
             & (c[ads_pkg::CTL_DO1] | c[ads_pkg::CTL_DO0]))
          | (f[ads_pkg::CFG_CIE] & f[ads_pkg::CFG_CI])
          | (f[ads_pkg::CFG_EOE] & f[ads_pkg::CFG_EO]);
  endfunction

  // Conversion 0 is drained first; it cannot starve 1 for long since
  // each buffer holds one word and refills only at the converter rate.
  assign fif.inValid  = |st.bufFull;
  assign fif.inData   = st.bufFull[0] ? {1'b0, st.bufData[0]}
                                      : {1'b1, st.bufData[1]};
  assign fif.outReady = !st.slotFull || (st.wrValid && ramWrReady);

  always_comb
  begin
    nxt_st   = st;
    ctrlWr   = sfrWrEn && addrHit(sfrAddr, ads_pkg::CTRL_ADDR);
    cfgWr    = sfrWrEn && addrHit(sfrAddr, ads_pkg::CFG_ADDR);
    rptNow   = (repeatCount == repeatLimit);
    convIn   = {conv1Valid, conv0Valid} & {2{st.ctrl[ads_pkg::CTL_EN]}};
    convData = {conv1Data, conv0Data};
    freed    = '0;
    if (fif.inValid && fif.inReady)
    begin
      freed = st.bufFull[0] ? 2'b01 : 2'b10;
    end
    // Software writes first so that a hardware set in the same cycle wins.
    if (ctrlWr)
    begin
      nxt_st.ctrl = sfrWrData;
    end
    if (cfgWr)
    begin
      nxt_st.cfg = sfrWrData & ads_pkg::CFG_WMASK;
    end
    for (int k = 0; k < 2; k++)
    begin
      if (freed[k])
      begin
        nxt_st.bufFull[k]  = st.pendFull[k];
        nxt_st.bufData[k]  = st.pendData[k];
        nxt_st.pendFull[k] = 1'b0;
      end
      if (convIn[k])
      begin
        if (!nxt_st.bufFull[k])
        begin
          nxt_st.bufFull[k] = 1'b1;
          nxt_st.bufData[k] = convData[k];
        end
        else if (!nxt_st.pendFull[k])
        begin
          nxt_st.pendFull[k] = 1'b1;
          nxt_st.pendData[k] = convData[k];
          nxt_st.ctrl[k == 0 ? ads_pkg::CTL_DO0
                             : ads_pkg::CTL_DO1] = 1'b1;
        end
        else
        begin
          nxt_st.pendData[k] = convData[k];
          nxt_st.ctrl[k == 0 ? ads_pkg::CTL_DE0
                             : ads_pkg::CTL_DE1] = 1'b1;
        end
      end
    end
    nxt_st.rptHit = rptNow;
    if (rptNow && !st.rptHit)
    begin
      nxt_st.cfg[ads_pkg::CFG_CI] = 1'b1;
    end
    if (eopReached)
    begin
      nxt_st.cfg[ads_pkg::CFG_EO] = 1'b1;
    end
    if (opsComplete)
    begin
      nxt_st.ctrl[ads_pkg::CTL_DONE] = 1'b1;
    end
    if (st.wrValid && ramWrReady)
    begin
      nxt_st.slotFull = 1'b0;
    end
    if (fif.outValid && fif.outReady)
    begin
      nxt_st.slotFull = 1'b1;
      nxt_st.wrData   = fif.outData;
    end
    // A held word stays in the slot and is offered again after release.
    nxt_st.wrValid = nxt_st.slotFull && !nxt_st.cfg[ads_pkg::CFG_HALT];
    if (sfrRdEn)
    begin
      if (addrHit(sfrAddr, ads_pkg::CTRL_ADDR))
      begin
        nxt_st.rdData = st.ctrl;
      end
      else if (addrHit(sfrAddr, ads_pkg::CFG_ADDR))
      begin
        nxt_st.rdData = st.cfg;
        nxt_st.rdData[ads_pkg::CFG_BUSY] = st.slotFull;
      end
      else
      begin
        nxt_st.rdData = 8'h00;
      end
    end
    nxt_st.irq = irqOf(nxt_st.ctrl, nxt_st.cfg);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st      <= '0;
      st.ctrl <= ads_pkg::CTRL_RST;
      st.cfg  <= ads_pkg::CFG_RST;
    end
    else
    begin
      st <= nxt_st;
    end
  end

  assign sfrRdData  = st.rdData;
  assign ramWrValid = st.wrValid;
  assign ramWrData  = st.wrData;
  assign dmaEnable  = st.ctrl[ads_pkg::CTL_EN];
  assign dmaMode    = st.ctrl[ads_pkg::CTL_MODE];
  assign dmaIrq     = st.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence lostResult0;
    conv0Valid && st.ctrl[ads_pkg::CTL_EN] && st.bufFull[0]
      && st.pendFull[0] && !freed[0];
  endsequence

  sequence warnOnly;
    ((st.ctrl & 8'h58) == 8'h00) && (st.cfg[ads_pkg::CFG_EO] == 1'b0)
      && (st.cfg[ads_pkg::CFG_CI] == 1'b0)
      && (st.ctrl[ads_pkg::CTL_DO0] || st.ctrl[ads_pkg::CTL_DO1]);
  endsequence

  sequence repeatOnly;
    ((st.ctrl & 8'h5F) == 8'h00) && st.cfg[ads_pkg::CFG_CI]
      && !st.cfg[ads_pkg::CFG_CIE] && !st.cfg[ads_pkg::CFG_EO];
  endsequence

  chk_err0_set: assert property (
    lostResult0 |=> st.ctrl[ads_pkg::CTL_DE0])
    else $error("Lost converter-0 result did not set the error flag.");

  chk_err_sticky: assert property (
    st.ctrl[ads_pkg::CTL_DE0] && !ctrlWr |=> st.ctrl[ads_pkg::CTL_DE0])
    else $error("Error flag dropped without a software write.");

  chk_warn1_set: assert property (
    conv1Valid && st.ctrl[ads_pkg::CTL_EN] && st.bufFull[1]
      && !st.pendFull[1] && !freed[1] |=> st.ctrl[ads_pkg::CTL_DO1])
    else $error("Full converter-1 buffer did not set the warning flag.");

  chk_cie_gate: assert property (
    repeatOnly |-> !dmaIrq)
    else $error("Repeat overflow raised an interrupt while disabled.");

  chk_ci_set: assert property (
    (repeatCount == repeatLimit) && !st.rptHit
      |=> st.cfg[ads_pkg::CFG_CI] ##1 st.cfg[ads_pkg::CFG_CI] || $past(cfgWr))
    else $error("Repeat overflow flag not set on reaching the limit.");

  chk_halt_holds: assert property (
    st.cfg[ads_pkg::CFG_HALT] |-> !ramWrValid)
    else $error("RAM write offered while halted.");

  chk_halt_resume: assert property (
    $fell(st.cfg[ads_pkg::CFG_HALT]) && st.slotFull |-> ramWrValid)
    else $error("Held RAM write not offered after halt release.");

  chk_doe_gate: assert property (
    warnOnly |-> dmaIrq == st.ctrl[ads_pkg::CTL_DOE])
    else $error("Warning interrupt does not follow the warning enable.");

  chk_limit_hit: assert property (
    st.rptHit |-> $past(repeatCount == repeatLimit))
    else $error("Repeat hit recorded without the counter at its limit.");
endmodule
`default_nettype wire

// file: verilog/ads_fifo.sv
// Result FIFO between the converter buffers and the RAM write stage.
`timescale 1ns/1ps
`default_nettype none
module ads_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Both sides
  ads_fifo_if.store fif
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } ads_fifo_st_t;

  ads_fifo_st_t st;
  ads_fifo_st_t nxt_st;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  assign fif.inReady  = (st.cnt != FULL_CNT);
  assign fif.outValid = (st.cnt != '0);
  assign fif.outData  = mem[st.rp];

  always_comb
  begin
    push   = fif.inValid && fif.inReady;
    pop    = fif.outValid && fif.outReady;
    nxt_st = st;
    if (push)
    begin
      nxt_st.wp = st.wp + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rp = st.rp + 1'b1;
    end
    if (push && !pop)
    begin
      nxt_st.cnt = st.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= nxt_st;
    end
  end

  // The storage has no reset; empty slots are never read out.
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[st.wp] <= fif.inData;
    end
  end
endmodule
`default_nettype wire

// file: verilog/ads_fifo_if.sv
// Valid/ready carrier between the status block and its result FIFO.
`timescale 1ns/1ps
`default_nettype none
interface ads_fifo_if #(
  parameter int W = 17
);
  logic         inValid;
  logic         inReady;
  logic [W-1:0] inData;
  logic         outValid;
  logic         outReady;
  logic [W-1:0] outData;

  modport producer (output inValid, output inData, input inReady,
                    input outValid, input outData, output outReady);
  modport store    (input inValid, input inData, output inReady,
                    output outValid, output outData, input outReady);
endinterface
`default_nettype wire

// file: verilog/ads_pkg.sv
// Constants shared by the converter DMA status block and its FIFO.
package ads_pkg;

  // Register addresses on the special function register port.
  localparam logic [7:0] CTRL_ADDR = 8'hD8;
  localparam logic [7:0] CFG_ADDR  = 8'hD9;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h00;

  // Writable bits of the configuration register; busy and reserved read.
  localparam logic [7:0] CFG_WMASK = 8'h8F;

  // Control register fields.
  localparam int CTL_EN   = 7;
  localparam int CTL_DONE = 6;
  localparam int CTL_MODE = 5;
  localparam int CTL_DE1  = 4;
  localparam int CTL_DE0  = 3;
  localparam int CTL_DOE  = 2;
  localparam int CTL_DO1  = 1;
  localparam int CTL_DO0  = 0;

  // Configuration register fields.
  localparam int CFG_HALT = 7;
  localparam int CFG_BUSY = 6;
  localparam int CFG_CIE  = 3;
  localparam int CFG_CI   = 2;
  localparam int CFG_EOE  = 1;
  localparam int CFG_EO   = 0;

  // Datapath sizes.
  localparam int DATA_W     = 16;
  localparam int COUNT_W    = 16;
  localparam int FIFO_DEPTH = 8;

endpackage
